// file: design/pdsr_pkg.sv
// Constants, ROM table and field helpers for the PLL divider and spread registers
// Overview of operation
// - Byte 12 holds CPU PLL feedback divider bits 7..0, read-write.
// - Byte 11 bits 7,6 hold CPU feedback bits 8,9; bits 5..0 reference divider.
// - VCO frequency is 14.318 MHz times (N plus 8) over (M plus 2).
// - At power-up divider and spread fields load from an internal ROM row.
// - Byte 15 bits 7 and 6 hold graphics feedback divider bits 8 and 9.
// - Byte 15 bits 5..0 hold the graphics PLL reference divider, read-write.
// - Byte 16 holds graphics feedback divider bits 7..0, completing the ten bits.
// - Byte 13 holds CPU spread setting bits 7..0, read-write.
// - Byte 14 bits 6..0 hold CPU spread bits 14..8; bit 7 reads zero.
// - Byte 17 holds graphics spread setting bits 7..0, read-write.
// - ROM divider values reach the PLLs at load; written ones only while the enable bit, reset zero, is set.
package pdsr_pkg;

    // ==================================================================
    // Register indexes
    localparam logic [7:0] IDX_PROG_EN = 8'h0A;
    localparam logic [7:0] IDX_CPU_DIV_HIGH = 8'h0B;
    localparam logic [7:0] IDX_CPU_FB_LOW = 8'h0C;
    localparam logic [7:0] IDX_CPU_SPREAD_LOW = 8'h0D;
    localparam logic [7:0] IDX_CPU_SPREAD_HIGH = 8'h0E;
    localparam logic [7:0] IDX_GFX_DIV_HIGH = 8'h0F;
    localparam logic [7:0] IDX_GFX_FB_LOW = 8'h10;
    localparam logic [7:0] IDX_GFX_SPREAD_LOW = 8'h11;

    // ==================================================================
    // Field layout and masks
    localparam int PROG_EN_BIT = 7;
    localparam int FB_BIT8_POS = 7;
    localparam int FB_BIT9_POS = 6;
    localparam logic [7:0] MASK_ALL = 8'hFF;
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] MASK_PROG_EN = 8'h80;
    localparam logic [7:0] MASK_SPREAD_HIGH = 8'h7F;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ==================================================================
    // Frequency arithmetic
    localparam logic [13:0] REF_KHZ = 14'h37EE;
    localparam logic [10:0] FB_OFFSET = 11'h008;
    localparam logic [6:0] REF_OFFSET = 7'h02;
    localparam int VCO_W = 24;

    typedef enum logic {PDSR_LOAD = 1'b0, PDSR_RUN = 1'b1} pdsr_state_t;

    typedef struct packed {
        logic [7:0] cpuDivHigh;
        logic [7:0] cpuFbLow;
        logic [7:0] cpuSpreadLow;
        logic [7:0] cpuSpreadHigh;
        logic [7:0] gfxDivHigh;
        logic [7:0] gfxFbLow;
        logic [7:0] gfxSpreadLow;
    } pdsr_rom_t;

    // Power-up default rows, selected by the row strap
    function automatic pdsr_rom_t pdsrRomRow(input logic [1:0] sel);
        pdsr_rom_t row;
        row = '0;
        unique case (sel)
            2'h0: row = '{8'h4C, 8'hF0, 8'h10, 8'h03, 8'h4C, 8'hB0, 8'h20};
            2'h1: row = '{8'h8A, 8'h20, 8'h18, 8'h04, 8'h4C, 8'hC8, 8'h20};
            2'h2: row = '{8'hCB, 8'h40, 8'h00, 8'h00, 8'h0C, 8'h90, 8'h00};
            2'h3: row = '{8'h0E, 8'h60, 8'h24, 8'h05, 8'h8C, 8'h10, 8'h30};
        endcase
        return row;
    endfunction : pdsrRomRow

    // Ten-bit feedback divider from the high byte and the low byte
    function automatic logic [9:0] pdsrFbDiv(input logic [7:0] hi, input logic [7:0] lo);
        return {hi[FB_BIT9_POS], hi[FB_BIT8_POS], lo};
    endfunction : pdsrFbDiv

    // Writable bits of each index; zero marks an unmapped index
    function automatic logic [7:0] pdsrWrMask(input logic [7:0] idx);
        logic [7:0] m;
        m = MASK_NONE;
        if (idx == IDX_PROG_EN) begin
            m = MASK_PROG_EN;
        end else if (idx == IDX_CPU_SPREAD_HIGH) begin
            m = MASK_SPREAD_HIGH;
        end else if (idx >= IDX_CPU_DIV_HIGH && idx <= IDX_GFX_SPREAD_LOW) begin
            m = MASK_ALL;
        end
        return m;
    endfunction : pdsrWrMask

endpackage : pdsr_pkg

// file: design/pdsr_regs.sv
// Divider and spread register file with ROM defaults and applied PLL settings
`timescale 1ns/1ps
module pdsr_regs
    import pdsr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [1:0] romSel,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [7:0] regIndex,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData,
    output logic progEnable,
    output logic [9:0] cpuFbDiv,
    output logic [5:0] cpuRefDiv,
    output logic [14:0] cpuSpread,
    output logic [9:0] gfxFbDiv,
    output logic [5:0] gfxRefDiv,
    output logic [7:0] gfxSpread,
    output logic [VCO_W-1:0] cpuVcoKhz,
    output logic [VCO_W-1:0] gfxVcoKhz,
    output logic vcoBusy
);

    pdsr_state_t state_r, state_nxt;
    pdsr_rom_t rom;
    logic progEn_r, progEn_nxt;
    logic [7:0] cpuDivHigh_r, cpuDivHigh_nxt, cpuFbLow_r, cpuFbLow_nxt;
    logic [7:0] cpuSpreadLow_r, cpuSpreadLow_nxt, cpuSpreadHigh_r, cpuSpreadHigh_nxt;
    logic [7:0] gfxDivHigh_r, gfxDivHigh_nxt, gfxFbLow_r, gfxFbLow_nxt;
    logic [7:0] gfxSpreadLow_r, gfxSpreadLow_nxt, rdData_r, rdData_nxt;
    logic [7:0] wrMask, wrBits;
    logic [9:0] cpuFb_r, cpuFb_nxt, gfxFb_r, gfxFb_nxt;
    logic [5:0] cpuRef_r, cpuRef_nxt, gfxRef_r, gfxRef_nxt;
    logic [14:0] cpuSpread_r, cpuSpread_nxt;
    logic [7:0] gfxSpread_r, gfxSpread_nxt;
    logic cpuStart_r, cpuStart_nxt, gfxStart_r, gfxStart_nxt;
    logic cpuBusy, gfxBusy, vcoBusy_r, vcoBusy_nxt;

    // Masked merge of a write into a stored byte
    function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [7:0] idx);
        return (idx == regIndex) ? ((old & ~wrMask) | wrBits) : old;
    endfunction : mergeByte

    // ==================================================================
    // Register file: ROM load, then bus writes
    always_comb begin
        rom = pdsrRomRow(romSel);
        wrMask = pdsrWrMask(regIndex);
        wrBits = wrData & wrMask;
        state_nxt = PDSR_RUN;
        progEn_nxt = progEn_r;
        cpuDivHigh_nxt = cpuDivHigh_r;
        cpuFbLow_nxt = cpuFbLow_r;
        cpuSpreadLow_nxt = cpuSpreadLow_r;
        cpuSpreadHigh_nxt = cpuSpreadHigh_r;
        gfxDivHigh_nxt = gfxDivHigh_r;
        gfxFbLow_nxt = gfxFbLow_r;
        gfxSpreadLow_nxt = gfxSpreadLow_r;
        unique case (state_r)
            PDSR_LOAD: begin
                cpuDivHigh_nxt = rom.cpuDivHigh;
                cpuFbLow_nxt = rom.cpuFbLow;
                cpuSpreadLow_nxt = rom.cpuSpreadLow;
                cpuSpreadHigh_nxt = rom.cpuSpreadHigh & MASK_SPREAD_HIGH;
                gfxDivHigh_nxt = rom.gfxDivHigh;
                gfxFbLow_nxt = rom.gfxFbLow;
                gfxSpreadLow_nxt = rom.gfxSpreadLow;
            end
            PDSR_RUN: begin
                if (wrEn) begin
                    progEn_nxt = (regIndex == IDX_PROG_EN) ?
                        wrData[PROG_EN_BIT] : progEn_r;
                    cpuDivHigh_nxt = mergeByte(cpuDivHigh_r, IDX_CPU_DIV_HIGH);
                    cpuFbLow_nxt = mergeByte(cpuFbLow_r, IDX_CPU_FB_LOW);
                    cpuSpreadLow_nxt = mergeByte(cpuSpreadLow_r, IDX_CPU_SPREAD_LOW);
                    cpuSpreadHigh_nxt = mergeByte(cpuSpreadHigh_r, IDX_CPU_SPREAD_HIGH);
                    gfxDivHigh_nxt = mergeByte(gfxDivHigh_r, IDX_GFX_DIV_HIGH);
                    gfxFbLow_nxt = mergeByte(gfxFbLow_r, IDX_GFX_FB_LOW);
                    gfxSpreadLow_nxt = mergeByte(gfxSpreadLow_r, IDX_GFX_SPREAD_LOW);
                end
            end
        endcase
    end

    // ==================================================================
    // Read path, one cycle after the request
    always_comb begin
        rdData_nxt = rdData_r;
        if (rdEn) begin
            unique case (regIndex)
                IDX_PROG_EN: rdData_nxt = {progEn_r, 7'h00};
                IDX_CPU_DIV_HIGH: rdData_nxt = cpuDivHigh_r;
                IDX_CPU_FB_LOW: rdData_nxt = cpuFbLow_r;
                IDX_CPU_SPREAD_LOW: rdData_nxt = cpuSpreadLow_r;
                IDX_CPU_SPREAD_HIGH: rdData_nxt = cpuSpreadHigh_r & MASK_SPREAD_HIGH;
                IDX_GFX_DIV_HIGH: rdData_nxt = gfxDivHigh_r;
                IDX_GFX_FB_LOW: rdData_nxt = gfxFbLow_r;
                IDX_GFX_SPREAD_LOW: rdData_nxt = gfxSpreadLow_r;
                default: rdData_nxt = BYTE_ZERO;
            endcase
        end
    end

    // ==================================================================
    // Settings applied to the PLLs
    always_comb begin
        cpuFb_nxt = cpuFb_r;
        cpuRef_nxt = cpuRef_r;
        gfxFb_nxt = gfxFb_r;
        gfxRef_nxt = gfxRef_r;
        cpuSpread_nxt = {cpuSpreadHigh_r[6:0], cpuSpreadLow_r};
        gfxSpread_nxt = gfxSpreadLow_r;
        if (state_r == PDSR_RUN && progEn_r) begin
            cpuFb_nxt = pdsrFbDiv(cpuDivHigh_r, cpuFbLow_r);
            cpuRef_nxt = cpuDivHigh_r[5:0];
            gfxFb_nxt = pdsrFbDiv(gfxDivHigh_r, gfxFbLow_r);
            gfxRef_nxt = gfxDivHigh_r[5:0];
        end else if (state_r == PDSR_LOAD) begin
            cpuFb_nxt = pdsrFbDiv(rom.cpuDivHigh, rom.cpuFbLow);
            cpuRef_nxt = rom.cpuDivHigh[5:0];
            gfxFb_nxt = pdsrFbDiv(rom.gfxDivHigh, rom.gfxFbLow);
            gfxRef_nxt = rom.gfxDivHigh[5:0];
        end
        cpuStart_nxt = (cpuFb_nxt != cpuFb_r) || (cpuRef_nxt != cpuRef_r) || state_r == PDSR_LOAD;
        gfxStart_nxt = (gfxFb_nxt != gfxFb_r) || (gfxRef_nxt != gfxRef_r) || state_r == PDSR_LOAD;
        // Pending starts count as busy so the flag has no gap before the divide runs
        vcoBusy_nxt = cpuStart_nxt || gfxStart_nxt || cpuStart_r || gfxStart_r || cpuBusy || gfxBusy;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= PDSR_LOAD;
            progEn_r <= 1'b0;
            cpuDivHigh_r <= BYTE_ZERO;
            cpuFbLow_r <= BYTE_ZERO;
            cpuSpreadLow_r <= BYTE_ZERO;
            cpuSpreadHigh_r <= BYTE_ZERO;
            gfxDivHigh_r <= BYTE_ZERO;
            gfxFbLow_r <= BYTE_ZERO;
            gfxSpreadLow_r <= BYTE_ZERO;
            rdData_r <= BYTE_ZERO;
            cpuFb_r <= '0;
            cpuRef_r <= '0;
            gfxFb_r <= '0;
            gfxRef_r <= '0;
            cpuSpread_r <= '0;
            gfxSpread_r <= BYTE_ZERO;
            cpuStart_r <= 1'b0;
            gfxStart_r <= 1'b0;
            vcoBusy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            progEn_r <= progEn_nxt;
            cpuDivHigh_r <= cpuDivHigh_nxt;
            cpuFbLow_r <= cpuFbLow_nxt;
            cpuSpreadLow_r <= cpuSpreadLow_nxt;
            cpuSpreadHigh_r <= cpuSpreadHigh_nxt;
            gfxDivHigh_r <= gfxDivHigh_nxt;
            gfxFbLow_r <= gfxFbLow_nxt;
            gfxSpreadLow_r <= gfxSpreadLow_nxt;
            rdData_r <= rdData_nxt;
            cpuFb_r <= cpuFb_nxt;
            cpuRef_r <= cpuRef_nxt;
            gfxFb_r <= gfxFb_nxt;
            gfxRef_r <= gfxRef_nxt;
            cpuSpread_r <= cpuSpread_nxt;
            gfxSpread_r <= gfxSpread_nxt;
            cpuStart_r <= cpuStart_nxt;
            gfxStart_r <= gfxStart_nxt;
            vcoBusy_r <= vcoBusy_nxt;
        end
    end

    // ==================================================================
    // Frequency calculators
    pdsr_vco_calc u_cpu_calc (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(cpuStart_r),
        .fbDiv(cpuFb_r),
        .refDiv(cpuRef_r),
        .vcoKhz(cpuVcoKhz),
        .busy(cpuBusy)
    );

    pdsr_vco_calc u_gfx_calc (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(gfxStart_r),
        .fbDiv(gfxFb_r),
        .refDiv(gfxRef_r),
        .vcoKhz(gfxVcoKhz),
        .busy(gfxBusy)
    );

    assign rdData = rdData_r;
    assign progEnable = progEn_r;
    assign cpuFbDiv = cpuFb_r;
    assign cpuRefDiv = cpuRef_r;
    assign cpuSpread = cpuSpread_r;
    assign gfxFbDiv = gfxFb_r;
    assign gfxRefDiv = gfxRef_r;
    assign gfxSpread = gfxSpread_r;
    assign vcoBusy = vcoBusy_r;

    // ==================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_cpu_fb_low;
        (wrEn && regIndex == IDX_CPU_FB_LOW && progEn_r && state_r == PDSR_RUN) ##1 !wrEn
            |-> ##1 cpuFbDiv[7:0] == $past(wrData, 2);
    endproperty
    a_cpu_fb_low: assert property (p_cpu_fb_low) else $error("CPU feedback low not applied");

    property p_cpu_high;
        (wrEn && regIndex == IDX_CPU_DIV_HIGH && progEn_r && state_r == PDSR_RUN) ##1 !wrEn
            |-> ##1 cpuFbDiv[9:8] == {$past(wrData[6], 2), $past(wrData[7], 2)}
            && cpuRefDiv == $past(wrData[5:0], 2);
    endproperty
    a_cpu_high: assert property (p_cpu_high) else $error("CPU high byte misplaced");

    property p_rom_load;
        $fell(reset) |-> ##1 cpuFbLow_r == $past(rom.cpuFbLow)
            && cpuDivHigh_r == $past(rom.cpuDivHigh) && state_r == PDSR_RUN;
    endproperty
    a_rom_load: assert property (p_rom_load) else $error("ROM defaults not loaded");

    property p_gfx_high;
        (wrEn && regIndex == IDX_GFX_DIV_HIGH && progEn_r && state_r == PDSR_RUN) ##1 !wrEn
            |-> ##1 gfxFbDiv[9:8] == {$past(wrData[6], 2), $past(wrData[7], 2)};
    endproperty
    a_gfx_high: assert property (p_gfx_high) else $error("Graphics N high misplaced");

    property p_gfx_ref;
        (wrEn && regIndex == IDX_GFX_DIV_HIGH && progEn_r && state_r == PDSR_RUN) ##1 !wrEn
            |-> ##1 gfxRefDiv == $past(wrData[5:0], 2);
    endproperty
    a_gfx_ref: assert property (p_gfx_ref) else $error("Graphics M not applied");

    property p_gfx_fb_low;
        (wrEn && regIndex == IDX_GFX_FB_LOW && progEn_r && state_r == PDSR_RUN) ##1 !wrEn
            |-> ##1 gfxFbDiv[7:0] == $past(wrData, 2);
    endproperty
    a_gfx_fb_low: assert property (p_gfx_fb_low) else $error("Graphics N low not applied");

    property p_cpu_spread;
        (wrEn && regIndex == IDX_CPU_SPREAD_LOW && state_r == PDSR_RUN) ##1 !wrEn
            |-> ##1 cpuSpread[7:0] == $past(wrData, 2);
    endproperty
    a_cpu_spread: assert property (p_cpu_spread) else $error("CPU spread low not applied");

    property p_spread_reserved;
        rdEn && regIndex == IDX_CPU_SPREAD_HIGH |=> !rdData[7];
    endproperty
    a_spread_reserved: assert property (p_spread_reserved) else $error("Reserved bit set");

    property p_gfx_spread;
        (wrEn && regIndex == IDX_GFX_SPREAD_LOW && state_r == PDSR_RUN) ##1 !wrEn
            |-> ##1 gfxSpread == $past(wrData, 2);
    endproperty
    a_gfx_spread: assert property (p_gfx_spread) else $error("Graphics spread not applied");

    property p_prog_gate;
        state_r == PDSR_RUN && !progEn_r |=> $stable(cpuFbDiv) && $stable(gfxFbDiv)
            && $stable(cpuRefDiv) && $stable(gfxRefDiv);
    endproperty
    a_prog_gate: assert property (p_prog_gate) else $error("Divider changed while disabled");

    property p_readback;
        (wrEn && state_r == PDSR_RUN) ##1 !wrEn
            ##1 (rdEn && !wrEn && regIndex == $past(regIndex, 2))
            |=> rdData == ($past(wrData, 3) & pdsrWrMask($past(regIndex, 3)));
    endproperty
    a_readback: assert property (p_readback) else $error("Readback mismatch");

    c_enable_apply: cover property (progEn_r ##1 $changed(cpuFbDiv));
    c_gfx_write: cover property (wrEn && regIndex == IDX_GFX_FB_LOW && progEn_r);
    c_spread_read: cover property (rdEn && regIndex == IDX_CPU_SPREAD_HIGH ##1 rdData != 8'h00);

endmodule : pdsr_regs

// file: design/pdsr_vco_calc.sv
// Sequential divider that turns the applied dividers into a VCO frequency in kHz
`timescale 1ns/1ps
module pdsr_vco_calc
    import pdsr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [9:0] fbDiv,
    input wire logic [5:0] refDiv,
    output logic [VCO_W-1:0] vcoKhz,
    output logic busy
);

    logic [VCO_W-1:0] num_r, num_nxt, quo_r, quo_nxt, vco_r, vco_nxt;
    logic [7:0] rem_r, rem_nxt, trial;
    logic [6:0] den_r, den_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;

    // ==================================================================
    // One quotient bit per cycle, restoring division
    always_comb begin
        num_nxt = num_r;
        quo_nxt = quo_r;
        rem_nxt = rem_r;
        den_nxt = den_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        vco_nxt = vco_r;
        trial = {rem_r[6:0], num_r[VCO_W-1]};
        if (start) begin
            num_nxt = VCO_W'(REF_KHZ) * VCO_W'({1'b0, fbDiv} + FB_OFFSET);
            den_nxt = {1'b0, refDiv} + REF_OFFSET;
            rem_nxt = BYTE_ZERO;
            quo_nxt = '0;
            cnt_nxt = 5'(VCO_W);
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            num_nxt = {num_r[VCO_W-2:0], 1'b0};
            if (trial >= {1'b0, den_r}) begin
                rem_nxt = trial - {1'b0, den_r};
                quo_nxt = {quo_r[VCO_W-2:0], 1'b1};
            end else begin
                rem_nxt = trial;
                quo_nxt = {quo_r[VCO_W-2:0], 1'b0};
            end
            cnt_nxt = cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
                busy_nxt = 1'b0;
                vco_nxt = quo_nxt;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            num_r <= '0;
            quo_r <= '0;
            rem_r <= BYTE_ZERO;
            den_r <= REF_OFFSET;
            cnt_r <= 5'h00;
            busy_r <= 1'b0;
            vco_r <= '0;
        end else begin
            num_r <= num_nxt;
            quo_r <= quo_nxt;
            rem_r <= rem_nxt;
            den_r <= den_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            vco_r <= vco_nxt;
        end
    end

    assign vcoKhz = vco_r;
    assign busy = busy_r;

    // ==================================================================
    // Checks
    logic [31:0] chkNum_r, chkDen_r;
    always_ff @(posedge ref_clk) begin
        if (start) begin
            chkNum_r <= 32'(REF_KHZ) * 32'({1'b0, fbDiv} + FB_OFFSET);
            chkDen_r <= 32'({1'b0, refDiv} + REF_OFFSET);
        end
    end

    property p_vco_quotient;
        @(posedge ref_clk) disable iff (reset)
        $fell(busy_r) && !start |-> (32'(vco_r) * chkDen_r <= chkNum_r)
            && ((32'(vco_r) + 32'h0000_0001) * chkDen_r > chkNum_r);
    endproperty
    a_vco_quotient: assert property (p_vco_quotient) else $error("VCO quotient wrong");

    property p_vco_latency;
        @(posedge ref_clk) disable iff (reset)
        start ##1 (!start) [*8] |-> busy_r ##[1:17] !busy_r;
    endproperty
    a_vco_latency: assert property (p_vco_latency) else $error("VCO divide took too long");

    c_vco_done: cover property (@(posedge ref_clk) disable iff (reset) $fell(busy_r));

endmodule : pdsr_vco_calc

// file: verif/pdsr_host_model.sv
// Management bus host model driving the byte register port
`timescale 1ns/1ps
module pdsr_host_model (
    input wire logic ref_clk,
    input wire logic [7:0] rdData,
    output logic wrEn,
    output logic rdEn,
    output logic [7:0] regIndex,
    output logic [7:0] wrData
);
    initial begin
        wrEn = 1'b0;
        rdEn = 1'b0;
        regIndex = 8'h00;
        wrData = 8'h00;
    end

    // One-cycle write strobe; released data is inverted so stale values never match
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(negedge ref_clk);
        wrEn = 1'b1;
        regIndex = idx;
        wrData = d;
        @(negedge ref_clk);
        wrEn = 1'b0;
        wrData = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        @(negedge ref_clk);
        rdEn = 1'b1;
        regIndex = idx;
        @(negedge ref_clk);
        rdEn = 1'b0;
        regIndex = ~idx;
        d = rdData;
    endtask : rd
endmodule : pdsr_host_model

// file: verif/pdsr_regs_test.sv
// Self-checking bench for the PLL divider and spread register file
`timescale 1ns/1ps
module pdsr_regs_test;
    import pdsr_pkg::*;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] romSel = 2'h0;
    logic wrEn, rdEn;
    logic [7:0] regIndex, wrData, rdData, rv;
    logic progEnable;
    logic [9:0] cpuFbDiv, gfxFbDiv;
    logic [5:0] cpuRefDiv, gfxRefDiv;
    logic [14:0] cpuSpread;
    logic [7:0] gfxSpread;
    logic [VCO_W-1:0] cpuVcoKhz, gfxVcoKhz;
    logic vcoBusy;
    int error_cnt = 0;
    int checks = 0;
    logic [7:0] rowIdx [8] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h0B, 8'h12};
    logic [7:0] rowWr [8] = '{8'hA5, 8'h5A, 8'hFF, 8'hC3, 8'h3C, 8'h96, 8'h81, 8'hFF};
    logic [7:0] rowRd [8] = '{8'hA5, 8'h5A, 8'h7F, 8'hC3, 8'h3C, 8'h96, 8'h81, 8'h00};

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    pdsr_regs i_pdsr_regs (.ref_clk(ref_clk), .reset(reset), .romSel(romSel), .wrEn(wrEn),
        .rdEn(rdEn), .regIndex(regIndex), .wrData(wrData), .rdData(rdData),
        .progEnable(progEnable), .cpuFbDiv(cpuFbDiv), .cpuRefDiv(cpuRefDiv),
        .cpuSpread(cpuSpread), .gfxFbDiv(gfxFbDiv), .gfxRefDiv(gfxRefDiv),
        .gfxSpread(gfxSpread), .cpuVcoKhz(cpuVcoKhz), .gfxVcoKhz(gfxVcoKhz),
        .vcoBusy(vcoBusy));

    pdsr_host_model i_pdsr_host_model (.ref_clk(ref_clk), .rdData(rdData), .wrEn(wrEn),
        .rdEn(rdEn), .regIndex(regIndex), .wrData(wrData));

    // ==================================================================
    // Shared tasks
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic doReset(input logic [1:0] sel);
        @(negedge ref_clk);
        reset = 1'b1;
        romSel = sel;
        repeat (10) @(negedge ref_clk);
        reset = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : doReset

    task automatic waitVco();
        int n;
        repeat (5) @(negedge ref_clk);
        for (n = 0; n < 200 && vcoBusy !== 1'b0; n++) begin
            @(negedge ref_clk);
        end
        if (n == 200) begin
            error_cnt++;
            $display("Error at %0t: frequency result never settled", $time);
            wrap_up();
        end
    endtask : waitVco

    function automatic logic [23:0] vco(input int n, input int m);
        return 24'(14318 * (n + 8) / (m + 2));
    endfunction : vco

    // ==================================================================
    // Main sequence
    initial begin
        doReset(2'h0);
        i_pdsr_host_model.rd(8'h0C, rv);
        chk(24'(rv), 24'h0000_F0);
        i_pdsr_host_model.rd(8'h0E, rv);
        chk(24'(rv), 24'h0000_03);
        chk(24'(cpuFbDiv), 24'h0002_F0);
        chk(24'(progEnable), 24'h0000_00);
        $display("Test power-up defaults done");
        for (int i = 0; i < 8; i++) begin
            i_pdsr_host_model.wr(rowIdx[i], rowWr[i]);
            i_pdsr_host_model.rd(rowIdx[i], rv);
            chk(24'(rv), 24'(rowRd[i]));
        end
        repeat (3) @(negedge ref_clk);
        chk(24'(cpuFbDiv), 24'h0002_F0);
        chk(24'(cpuRefDiv), 24'h0000_0C);
        chk(24'(cpuSpread), 24'h00_7F5A);
        chk(24'(gfxSpread), 24'h0000_96);
        $display("Test register rows done");
        i_pdsr_host_model.wr(IDX_PROG_EN, 8'hFF);
        i_pdsr_host_model.rd(IDX_PROG_EN, rv);
        chk(24'(rv), 24'h0000_80);
        chk(24'(vcoBusy), 24'h00_0001);
        waitVco();
        chk(24'(cpuFbDiv), 24'h0001_A5);
        chk(24'(cpuRefDiv), 24'h0000_01);
        chk(24'(gfxFbDiv), 24'h0003_3C);
        chk(24'(gfxRefDiv), 24'h0000_03);
        chk(cpuVcoKhz, vco(421, 1));
        chk(gfxVcoKhz, vco(828, 3));
        $display("Test enable and frequency done");
        i_pdsr_host_model.wr(8'h10, 8'h07);
        waitVco();
        chk(24'(gfxFbDiv), 24'h0003_07);
        chk(gfxVcoKhz, vco(775, 3));
        $display("Test live reprogram done");
        i_pdsr_host_model.wr(IDX_CPU_DIV_HIGH, 8'h45);
        i_pdsr_host_model.wr(IDX_CPU_FB_LOW, 8'h12);
        i_pdsr_host_model.wr(IDX_GFX_DIV_HIGH, 8'h8A);
        waitVco();
        chk(24'(cpuFbDiv), 24'h00_0212);
        chk(24'(cpuRefDiv), 24'h00_0005);
        chk(24'(gfxFbDiv), 24'h00_0107);
        chk(24'(gfxRefDiv), 24'h00_000A);
        chk(cpuVcoKhz, vco(530, 5));
        chk(gfxVcoKhz, vco(263, 10));
        $display("Test enabled rewrite done");
        doReset(2'h2);
        i_pdsr_host_model.rd(8'h0B, rv);
        chk(24'(rv), 24'h0000_CB);
        i_pdsr_host_model.rd(IDX_PROG_EN, rv);
        chk(24'(rv), 24'h0000_00);
        chk(24'(cpuFbDiv), 24'h0003_40);
        chk(24'(cpuRefDiv), 24'h0000_0B);
        $display("Test second reset done");
        wrap_up();
    end
endmodule : pdsr_regs_test
